// file: src/capture_mode_trigger_router.sv
// capture sequencing, trigger/event detection and six-line signal router
// assumes an AXI4-Lite master on clk_sys; pins are asynchronous to clk_sys
`timescale 1ns/1ps
`include "capture_router_regs.svh"

module capture_mode_trigger_router #(
    parameter int LEN_W = 32
) (
    input  wire logic                clk_sys,
    input  wire logic                nrst,
    // axi4-lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // routed line sources
    input  wire logic [5:0]          front_in,
    input  wire logic [5:0]          rear_in,
    input  wire logic [5:0]          back_in,
    input  wire logic [5:0]          logic_out,
    input  wire logic                sample_clk_int,
    // routed line destinations
    output logic [5:0]               logic_in,
    output logic [5:0]               rear_out,
    output logic [5:0]               rear_oe,
    output logic [5:0]               back_out,
    output logic [5:0]               back_oe,
    // sample stream
    input  wire logic                sample_valid,
    output logic                     store_en,
    output logic                     store_circular,
    output logic                     burst_start,
    output logic [31:0]              burst_stamp,
    output logic                     event_mark,
    output logic                     capture_busy
);

    localparam int ADC_W = LEN_W;

    initial begin
        if (LEN_W < 16 || LEN_W > 32)
            $error("LEN_W must be 16..32");
    end

    typedef struct packed {
        logic                        awv;
        logic [7:0]                  awa;
        logic                        wv;
        logic [31:0]                 wd;
        logic [3:0]                  ws;
        logic                        bv;
        logic [1:0]                  br;
        logic                        rv;
        logic [31:0]                 rd;
        logic [1:0]                  rr;
        logic [5:0]                  ctrl;
        logic [2:0]                  trig;
        logic [5:0]                  evt;
        logic [ADC_W-1:0]            post_len;
        logic [ADC_W-1:0]            pre_len;
        logic [15:0]                 blen;
        logic [11:0]                 rsrc;
        logic [17:0]                 rdst;
        logic                        multi;
        capture_router_pkg::cap_state_t st;
        logic [ADC_W-1:0]            cnt;
        logic [ADC_W-1:0]            mcnt;
        logic                        reserving;
        logic [15:0]                 bcnt;
        logic                        in_burst;
        logic [31:0]                 tstamp;
        logic [31:0]                 stamp;
        logic                        bstart;
        logic                        emark;
        logic [5:0]                  s1;
        logic [5:0]                  s2;
        logic [5:0]                  s3;
        logic [5:0]                  s_prev;
    } state_t;

    state_t cur_ff;
    state_t nxt_ff;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // edge on selected line three..five; sel 0 means none
    function automatic logic edge_hit(input logic [2:0] sel,
                                      input logic [5:0] now,
                                      input logic [5:0] prev);
        logic rise;
        logic fall;
        rise = 1'b0;
        fall = 1'b0;
        if (sel[1:0] != 2'b00) begin
            rise = now[3'd2 + sel[1:0]] & ~prev[3'd2 + sel[1:0]];
            fall = ~now[3'd2 + sel[1:0]] & prev[3'd2 + sel[1:0]];
        end
        return sel[`CR_SEL_RISE_BIT] ? rise : fall;
    endfunction : edge_hit

    function automatic logic [31:0] wmerge(input logic [31:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i])
                r[i*8 +: 8] = d[i*8 +: 8];
        end
        return r;
    endfunction : wmerge

    ////////////////////////////////////////////////////////////////////////
    // router

    logic [5:0] line_val;

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            case (capture_router_pkg::route_src_t'(cur_ff.rsrc[i*2 +: 2]))
                capture_router_pkg::SRC_FRONT:
                    line_val[i] = (i == 0 || i == 3) ? front_in[i]
                                                     : 1'b0;
                capture_router_pkg::SRC_LOGIC:
                    line_val[i] = (i == 0) ? sample_clk_int
                                           : logic_out[i];
                capture_router_pkg::SRC_REAR: line_val[i] = rear_in[i];
                default:                      line_val[i] = back_in[i];
            endcase
        end
    end

    always_comb begin
        for (int i = 0; i < 6; i++) begin
            logic_in[i] = cur_ff.rdst[i*3] & line_val[i];
            if (i < 3) begin
                // push-pull; source must not also be the target
                rear_out[i] = line_val[i];
                back_out[i] = line_val[i];
                rear_oe[i]  = cur_ff.rdst[i*3+1];
                back_oe[i]  = cur_ff.rdst[i*3+2];
            end else begin
                // open collector: drive low only
                rear_out[i] = 1'b0;
                back_out[i] = 1'b0;
                rear_oe[i]  = cur_ff.rdst[i*3+1] & ~line_val[i];
                back_oe[i]  = cur_ff.rdst[i*3+2] & ~line_val[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // sequencer and registers

    logic trig_hit;
    logic ev0_hit;
    logic ev1_hit;
    logic ev_hit;
    logic gate_now;
    logic gate_rise;
    logic gate_fall;

    always_comb begin
        logic [5:0] now;
        logic       wr;
        logic       rd;
        logic       start_cmd;
        logic       has_trig;
        logic       single;
        capture_router_pkg::capture_mode_t mode;
        capture_router_pkg::gate_mode_t    gmode;
        now = '0;
        wr = 1'b0;
        rd = 1'b0;
        start_cmd = 1'b0;
        has_trig = 1'b0;
        single = 1'b0;
        mode = capture_router_pkg::MODE_SINGLE_SHOT;
        gmode = capture_router_pkg::GATE_OFF;
        nxt_ff = cur_ff;
        nxt_ff.bstart = 1'b0;
        nxt_ff.emark = 1'b0;

        // line samples: three stages, change taken when 2nd and 3rd agree
        nxt_ff.s1 = logic_in;
        nxt_ff.s2 = cur_ff.s1;
        nxt_ff.s3 = cur_ff.s2;
        for (int i = 0; i < 6; i++) begin
            nxt_ff.s_prev[i] = (cur_ff.s2[i] == cur_ff.s3[i])
                               ? cur_ff.s3[i] : cur_ff.s_prev[i];
        end
        now = nxt_ff.s_prev;

        trig_hit = edge_hit(cur_ff.trig, now, cur_ff.s_prev);
        ev0_hit  = edge_hit(cur_ff.evt[2:0], now, cur_ff.s_prev);
        ev1_hit  = edge_hit(cur_ff.evt[5:3], now, cur_ff.s_prev);
        ev_hit   = ev0_hit | ev1_hit;
        // gate level follows first event detector's line and sense
        gate_now = (cur_ff.evt[1:0] != 2'b00)
                 & (now[3'd2 + cur_ff.evt[1:0]] == cur_ff.evt[2]);
        gate_rise = ev0_hit;
        gate_fall = (cur_ff.evt[1:0] != 2'b00)
                  & ~gate_now
                  & (cur_ff.s_prev[3'd2 + cur_ff.evt[1:0]] == cur_ff.evt[2]);

        mode  = capture_router_pkg::capture_mode_t'(cur_ff.ctrl[1:0]);
        gmode = capture_router_pkg::gate_mode_t'(cur_ff.ctrl[5:4]);
        has_trig = cur_ff.trig[1:0] != 2'b00;
        single = (mode == capture_router_pkg::MODE_SINGLE_SHOT)
               | (mode == capture_router_pkg::MODE_TRIG_SINGLE);

        // axi write
        if (s_axi_awvalid && !cur_ff.awv && !cur_ff.bv) begin
            nxt_ff.awv = 1'b1;
            nxt_ff.awa = s_axi_awaddr;
        end
        if (s_axi_wvalid && !cur_ff.wv && !cur_ff.bv) begin
            nxt_ff.wv = 1'b1;
            nxt_ff.wd = s_axi_wdata;
            nxt_ff.ws = s_axi_wstrb;
        end
        wr = cur_ff.awv && cur_ff.wv;
        if (wr) begin
            nxt_ff.awv = 1'b0;
            nxt_ff.wv = 1'b0;
            nxt_ff.bv = 1'b1;
            nxt_ff.br = `CR_RESP_OKAY;
            case (cur_ff.awa)
                `CR_ADDR_CTRL: begin
                    nxt_ff.ctrl = cur_ff.ws[0] ? {cur_ff.wd[5:4], 2'b00,
                                  cur_ff.wd[1:0]} : cur_ff.ctrl;
                    nxt_ff.multi = cur_ff.ws[0] ? cur_ff.wd[6] : cur_ff.multi;
                    start_cmd = cur_ff.ws[0] & cur_ff.wd[`CR_CTRL_START_BIT];
                    if (cur_ff.ws[0] && cur_ff.wd[`CR_CTRL_REARM_BIT])
                        nxt_ff.st = capture_router_pkg::ST_IDLE;
                end
                `CR_ADDR_TRIG:
                    nxt_ff.trig = 3'(wmerge({29'h0, cur_ff.trig}, cur_ff.wd,
                                         cur_ff.ws));
                `CR_ADDR_EVENT:
                    nxt_ff.evt = 6'(wmerge({26'h0, cur_ff.evt}, cur_ff.wd,
                                        cur_ff.ws));
                `CR_ADDR_POST_LEN:
                    nxt_ff.post_len = ADC_W'(wmerge(32'(cur_ff.post_len),
                                                    cur_ff.wd, cur_ff.ws));
                `CR_ADDR_PRE_LEN:
                    nxt_ff.pre_len = ADC_W'(wmerge(32'(cur_ff.pre_len),
                                                   cur_ff.wd, cur_ff.ws));
                `CR_ADDR_BURST:
                    nxt_ff.blen = 16'(wmerge({16'h0, cur_ff.blen}, cur_ff.wd,
                                         cur_ff.ws));
                `CR_ADDR_ROUTE_SRC:
                    nxt_ff.rsrc = 12'(wmerge({20'h0, cur_ff.rsrc}, cur_ff.wd,
                                         cur_ff.ws));
                `CR_ADDR_ROUTE_DST:
                    nxt_ff.rdst = 18'(wmerge({14'h0, cur_ff.rdst}, cur_ff.wd,
                                         cur_ff.ws));
                default: nxt_ff.br = `CR_RESP_SLVERR;
            endcase
        end
        if (cur_ff.bv && s_axi_bready)
            nxt_ff.bv = 1'b0;

        // axi read
        rd = s_axi_arvalid && !cur_ff.rv;
        if (rd) begin
            nxt_ff.rv = 1'b1;
            nxt_ff.rr = `CR_RESP_OKAY;
            case (s_axi_araddr)
                `CR_ADDR_CTRL:      nxt_ff.rd = {25'h0, cur_ff.multi,
                                                 cur_ff.ctrl};
                `CR_ADDR_TRIG:      nxt_ff.rd = {29'h0, cur_ff.trig};
                `CR_ADDR_EVENT:     nxt_ff.rd = {26'h0, cur_ff.evt};
                `CR_ADDR_POST_LEN:  nxt_ff.rd = 32'(cur_ff.post_len);
                `CR_ADDR_PRE_LEN:   nxt_ff.rd = 32'(cur_ff.pre_len);
                `CR_ADDR_BURST:     nxt_ff.rd = {16'h0, cur_ff.blen};
                `CR_ADDR_ROUTE_SRC: nxt_ff.rd = {20'h0, cur_ff.rsrc};
                `CR_ADDR_ROUTE_DST: nxt_ff.rd = {14'h0, cur_ff.rdst};
                `CR_ADDR_STATUS:    nxt_ff.rd = {27'h0, cur_ff.reserving,
                                                 cur_ff.in_burst, cur_ff.st};
                `CR_ADDR_STAMP:     nxt_ff.rd = cur_ff.stamp;
                default: begin
                    nxt_ff.rd = 32'h0;
                    nxt_ff.rr = `CR_RESP_SLVERR;
                end
            endcase
        end
        if (cur_ff.rv && s_axi_rready)
            nxt_ff.rv = 1'b0;

        // free-running sample time for burst stamps
        if (sample_valid)
            nxt_ff.tstamp = cur_ff.tstamp + 32'h1;

        case (cur_ff.st)
            capture_router_pkg::ST_IDLE: begin
                nxt_ff.in_burst = 1'b0;
                nxt_ff.reserving = 1'b0;
                if (start_cmd)
                    nxt_ff.st = has_trig ? capture_router_pkg::ST_ARMED
                                         : capture_router_pkg::ST_PRE;
                nxt_ff.cnt = '0;
            end
            capture_router_pkg::ST_ARMED:
                if (trig_hit)
                    nxt_ff.st = capture_router_pkg::ST_PRE;
            capture_router_pkg::ST_PRE: begin
                // events only seen once capture runs
                if (ev_hit && (mode == capture_router_pkg::MODE_PRE_POST ||
                    mode == capture_router_pkg::MODE_CONTINUOUS)
                    && !cur_ff.multi) begin
                    nxt_ff.st = capture_router_pkg::ST_POST;
                    nxt_ff.cnt = '0;
                    nxt_ff.emark = 1'b1;
                end else if (single) begin
                    nxt_ff.st = capture_router_pkg::ST_POST;
                    nxt_ff.cnt = '0;
                end
            end
            capture_router_pkg::ST_POST:
                if (sample_valid && store_en) begin
                    nxt_ff.cnt = cur_ff.cnt + ADC_W'(1);
                    if (cur_ff.cnt + ADC_W'(1) >= cur_ff.post_len
                        && mode != capture_router_pkg::MODE_CONTINUOUS)
                        nxt_ff.st = capture_router_pkg::ST_DONE;
                end
            capture_router_pkg::ST_DONE: ;
            default: nxt_ff.st = capture_router_pkg::ST_IDLE;
        endcase

        // multi-event: reserve post_len window after every event
        if (cur_ff.multi && cur_ff.st == capture_router_pkg::ST_PRE) begin
            if (ev_hit) begin
                nxt_ff.reserving = 1'b1;
                nxt_ff.mcnt = '0;
                nxt_ff.emark = 1'b1;
            end else if (cur_ff.reserving && sample_valid) begin
                nxt_ff.mcnt = cur_ff.mcnt + ADC_W'(1);
                if (cur_ff.mcnt + ADC_W'(1) >= cur_ff.post_len)
                    nxt_ff.reserving = 1'b0;
            end
        end

        // repeating gate bursts
        if (gmode != capture_router_pkg::GATE_OFF &&
            cur_ff.st != capture_router_pkg::ST_IDLE &&
            cur_ff.st != capture_router_pkg::ST_ARMED &&
            cur_ff.st != capture_router_pkg::ST_DONE) begin
            if (!cur_ff.in_burst && gate_rise) begin
                nxt_ff.in_burst = 1'b1;
                nxt_ff.bcnt = '0;
                nxt_ff.bstart = 1'b1;
                nxt_ff.stamp = cur_ff.tstamp;
            end else if (cur_ff.in_burst) begin
                if (sample_valid)
                    nxt_ff.bcnt = cur_ff.bcnt + 16'h1;
                if ((gmode != capture_router_pkg::GATE_TRAN && gate_fall) ||
                    (gmode != capture_router_pkg::GATE_GATE && sample_valid
                     && cur_ff.bcnt + 16'h1 >= cur_ff.blen))
                    nxt_ff.in_burst = 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            cur_ff      <= '0;
            cur_ff.rsrc <= `CR_ROUTE_SRC_RESET;
            cur_ff.rdst <= `CR_ROUTE_DST_RESET;
            cur_ff.st   <= capture_router_pkg::ST_IDLE;
        end else begin
            cur_ff <= nxt_ff;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    logic running;
    assign running = cur_ff.st == capture_router_pkg::ST_PRE
                   || cur_ff.st == capture_router_pkg::ST_POST;

    always_comb begin
        if (cur_ff.ctrl[5:4] != 2'b00)
            store_en = running & cur_ff.in_burst & sample_valid;
        else
            store_en = running & sample_valid;
    end

    assign store_circular = cur_ff.st == capture_router_pkg::ST_PRE
                          && cur_ff.ctrl[1:0] != 2'b00
                          && cur_ff.ctrl[1:0] != 2'b10;
    assign s_axi_awready  = !cur_ff.awv && !cur_ff.bv;
    assign s_axi_wready   = !cur_ff.wv && !cur_ff.bv;
    assign s_axi_bvalid   = cur_ff.bv;
    assign s_axi_bresp    = cur_ff.br;
    assign s_axi_arready  = !cur_ff.rv;
    assign s_axi_rvalid   = cur_ff.rv;
    assign s_axi_rdata    = cur_ff.rd;
    assign s_axi_rresp    = cur_ff.rr;
    assign burst_start    = cur_ff.bstart;
    assign burst_stamp    = cur_ff.stamp;
    assign event_mark     = cur_ff.emark;
    assign capture_busy   = running || cur_ff.st == capture_router_pkg::ST_ARMED;

endmodule : capture_mode_trigger_router

// file: src/capture_router_pkg.sv
// types for the capture sequencer and signal router
// assumes the register header is included by the top module
package capture_router_pkg;

    typedef enum logic [1:0] {
        MODE_SINGLE_SHOT   = 2'b00,
        MODE_CONTINUOUS    = 2'b01,
        MODE_TRIG_SINGLE   = 2'b10,
        MODE_PRE_POST      = 2'b11
    } capture_mode_t;

    typedef enum logic [1:0] {
        GATE_OFF       = 2'b00,
        GATE_TRAN      = 2'b01,
        GATE_GATE      = 2'b10,
        GATE_TRAN_GATE = 2'b11
    } gate_mode_t;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ARMED = 3'b001,
        ST_PRE   = 3'b010,
        ST_POST  = 3'b011,
        ST_DONE  = 3'b100
    } cap_state_t;

    typedef enum logic [1:0] {
        SRC_FRONT = 2'b00,
        SRC_LOGIC = 2'b01,
        SRC_REAR  = 2'b10,
        SRC_BACK  = 2'b11
    } route_src_t;

    typedef struct packed {
        logic [2:0] sel;
    } edge_sel_t;

    typedef struct packed {
        logic [5:0] front_in;
        logic [5:0] logic_out;
        logic [5:0] rear_in;
        logic [5:0] back_in;
    } line_inputs_t;

endpackage : capture_router_pkg

// file: src/capture_router_regs.svh
// offsets, field positions and reset values of the capture router
// assumes inclusion by the top module only
`ifndef CAPTURE_ROUTER_REGS_SVH
`define CAPTURE_ROUTER_REGS_SVH

`define CR_ADDR_CTRL        8'h00
`define CR_ADDR_TRIG        8'h04
`define CR_ADDR_EVENT       8'h08
`define CR_ADDR_POST_LEN    8'h0c
`define CR_ADDR_BURST       8'h10
`define CR_ADDR_ROUTE_SRC   8'h14
`define CR_ADDR_ROUTE_DST   8'h18
`define CR_ADDR_STATUS      8'h1c
`define CR_ADDR_STAMP       8'h20
`define CR_ADDR_PRE_LEN     8'h24

// ctrl: [1:0] mode, [2] start, [3] rearm/stop, [5:4] gate mode
`define CR_CTRL_MODE_LSB    0
`define CR_CTRL_START_BIT   2
`define CR_CTRL_REARM_BIT   3
`define CR_CTRL_GATE_LSB    4
// trigger/event select: [1:0] line (0 none, 1..3 = line 3..5), [2] rising
`define CR_SEL_RISE_BIT     2
// route src: 2 bits per line; route dst: 3 bits per line
`define CR_ROUTE_SRC_RESET  12'h000
`define CR_ROUTE_DST_RESET  18'h00000
`define CR_RESP_OKAY        2'b00
`define CR_RESP_SLVERR      2'b10

`endif

// file: test/cap_router_chk.sv
// port assertions for the capture router
// assumes binding to capture_mode_trigger_router
`timescale 1ns/1ps
module cap_router_chk (
    input wire logic        clk_sys,
    input wire logic        nrst,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        sample_valid,
    input wire logic        store_en,
    input wire logic        store_circular,
    input wire logic        event_mark,
    input wire logic        capture_busy,
    input wire logic [5:0]  back_out,
    input wire logic [5:0]  rear_out
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    property p_store; store_en |-> sample_valid && capture_busy; endproperty
    a_store: assert property (p_store)
        else $error("store outside capture");
    property p_circ; store_circular |-> capture_busy; endproperty
    a_circ: assert property (p_circ)
        else $error("circular while idle");
    property p_mark; event_mark |=> !event_mark; endproperty
    a_mark: assert property (p_mark)
        else $error("event mark too long");
    property p_oc; back_out[5:3] == 3'h0 && rear_out[5:3] == 3'h0;
    endproperty
    a_oc: assert property (p_oc)
        else $error("upper line driven high");
    property p_bhold; s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_bhold: assert property (p_bhold)
        else $error("write response dropped");
    property p_rhold; s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
    a_rhold: assert property (p_rhold)
        else $error("read data dropped");
    property p_wans; s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##[1:2] s_axi_bvalid; endproperty
    a_wans: assert property (p_wans)
        else $error("no write response");
    property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rans: assert property (p_rans)
        else $error("no read response");
endmodule : cap_router_chk
bind capture_mode_trigger_router cap_router_chk i_chk (.clk_sys, .nrst,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
    .sample_valid, .store_en, .store_circular, .event_mark,
    .capture_busy, .back_out, .rear_out);

// file: test/capture_mode_trigger_router_bench.sv
// self-checking bench for the capture router
// assumes the checker bind and line_sources are compiled
`timescale 1ns/1ps
module capture_mode_trigger_router_bench;
    logic clk_sys = 1'b0, nrst = 1'b0;
    logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, burst_stamp, rd_d;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_bready = 1'b1, s_axi_rready = 1'b1;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, store_en, store_circular, burst_start;
    logic event_mark, capture_busy, sample_clk_int = 1'b0;
    logic sample_valid = 1'b0;
    logic [1:0] s_axi_bresp, s_axi_rresp, r2;
    logic [5:0] front_in, rear_in, back_in, logic_in, rear_out, rear_oe;
    logic [5:0] back_out, back_oe, logic_out = 6'h00, v;
    logic [5:0] fl = 6'h00, rl = 6'h00, bl = 6'h38;
    int errors = 0, checks = 0, n;
    always #2 clk_sys = ~clk_sys;
    always @(posedge clk_sys) sample_valid <= 1'($urandom);
    capture_mode_trigger_router i_capture_mode_trigger_router (.*);
    line_sources i_line_sources (.clk_sys, .f_lvl(fl), .r_lvl(rl),
        .b_lvl(bl), .back_oe, .front_in, .rear_in, .back_in);
    task automatic tally_and_finish;
        $display("errors %0d checks %0d", errors, checks);
        if (errors == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tmo(input int k, input int lim);
        if (k >= lim) begin
            errors++;
            tally_and_finish();
        end
    endtask : tmo
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw, tb;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_awvalid & s_axi_awready;
            tw = s_axi_wvalid & s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge clk_sys);
            if (ta) s_axi_awvalid <= 1'b0;
            if (tw) s_axi_wvalid <= 1'b0;
            n++;
        end while (!tb && n < 50);
        tmo(n, 50);
    endtask : wr
    task automatic rd(input logic [7:0] a);
        logic ta, tr;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(negedge clk_sys);
            ta = s_axi_arvalid & s_axi_arready;
            tr = s_axi_rvalid;
            rd_d = s_axi_rdata;
            r2 = s_axi_rresp;
            @(posedge clk_sys);
            if (ta) s_axi_arvalid <= 1'b0;
            n++;
        end while (!tr && n < 50);
        tmo(n, 50);
    endtask : rd
    task automatic st(input logic [2:0] e);
        repeat (12) @(posedge clk_sys);
        rd(8'h1c);
        chk(rd_d[2:0], e);
    endtask : st
    task automatic done_chk;
        repeat (2) @(negedge clk_sys);
        for (n = 0; n < 200 && capture_busy !== 1'b0; n++)
            @(negedge clk_sys);
        tmo(n, 200);
        st(3'h4);
    endtask : done_chk
    initial begin
        void'($urandom(35821));
        repeat (16) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        rd(8'h00);
        chk(rd_d, 32'h0);
        rd(8'h3c);
        chk(rd_d, 32'h0);
        chk(r2, 2'b10);
        for (int k = 0; k < 4; k++) begin
            wr(8'h14, {20'h0, {6{k[1:0]}}});
            wr(8'h18, {14'h0, {6{k < 3, k != 2, 1'b1}}});
            repeat (4) begin
                fl <= 6'($urandom);
                rl <= 6'($urandom);
                bl <= 6'($urandom);
                logic_out <= 6'($urandom);
                sample_clk_int <= 1'($urandom);
                repeat (2) @(posedge clk_sys);
                @(negedge clk_sys);
                case (k)
                    0: v = fl & 6'h09;
                    1: v = {logic_out[5:1], sample_clk_int};
                    2: v = rl;
                    default: v = bl;
                endcase
                chk(logic_in, v);
                if (k < 3) chk({back_oe, back_out}, {~v[5:3], 3'h7,
                    3'h0, v[2:0]});
                if (k != 2) chk({rear_oe, rear_out},
                    {~v[5:3], 3'h7, 3'h0, v[2:0]});
                @(posedge clk_sys);
            end
        end
        bl <= 6'h38;
        wr(8'h14, 32'hfc0);
        wr(8'h18, 32'h9249);
        wr(8'h0c, 32'h3);
        wr(8'h04, 32'h0);
        wr(8'h00, 32'h4);
        done_chk();
        wr(8'h04, 32'h5);
        bl <= 6'h30;
        st(3'h4);
        bl <= 6'h38;
        st(3'h4);
        for (int m = 0; m < 3; m += 2) begin
            wr(8'h00, 32'h8);
            wr(8'h00, 32'h4 | m);
            st(3'h1);
            bl <= 6'h30;
            st(3'h1);
            bl <= 6'h38;
            done_chk();
        end
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h2);
        wr(8'h00, 32'h8);
        wr(8'h00, 32'h7);
        st(3'h2);
        @(negedge clk_sys);
        chk(store_circular, 1'b1);
        bl <= 6'h28;
        for (n = 0; n < 20 && event_mark !== 1'b1; n++)
            @(negedge clk_sys);
        tmo(n, 20);
        done_chk();
        bl <= 6'h38;
        wr(8'h00, 32'h8);
        wr(8'h00, 32'h14);
        bl <= 6'h28;
        for (n = 0; n < 20 && burst_start !== 1'b1; n++)
            @(negedge clk_sys);
        tmo(n, 20);
        tally_and_finish();
    end
endmodule : capture_mode_trigger_router_bench

// file: test/line_sources.sv
// far-side sources of the six routed lines
// assumes the bench sets the wanted levels
`timescale 1ns/1ps
module line_sources (
    input  wire logic       clk_sys,
    input  wire logic [5:0] f_lvl,
    input  wire logic [5:0] r_lvl,
    input  wire logic [5:0] b_lvl,
    input  wire logic [5:0] back_oe,
    output logic      [5:0] front_in,
    output logic      [5:0] rear_in,
    output logic      [5:0] back_in
);
    logic [5:0] b_ff;
    always_ff @(posedge clk_sys) begin
        front_in <= f_lvl;
        rear_in  <= r_lvl;
        b_ff     <= b_lvl;
    end
    // upper lines pulled up, any driver pulls low
    assign back_in = b_ff & ~(back_oe & 6'h38);
endmodule : line_sources
